// ==== hdl/tic_glitch_filter.sv ====
`timescale 1ns/1ps
module tic_glitch_filter (
	input  wire logic  pclk,    // System clock
	input  wire logic  presetn, // Async reset, active low
	tic_flt_if.filt    fl       // Raw pins in, filtered levels out
);

	typedef struct packed {
		logic [11:0]       s1;
		logic [11:0]       s2;
		logic [11:0]       s3;
		logic [11:0]       lvl;
		logic [11:0][19:0] cnt;
	} tic_flt_state_t;

	tic_flt_state_t r;
	tic_flt_state_t next_r;
	logic [19:0]    thr;

	// Threshold in eighths of a filter step
	assign thr = {1'b0, fl.filter_time, 3'h0};
	assign fl.levels = r.lvl;

	// Three-stage synchroniser, then stability counter per input
	always_comb begin
		next_r = r;
		next_r.s1 = fl.raw;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		for (int i = 0; i < 12; i++) begin
			if ((r.s2[i] == r.s3[i]) && (r.s3[i] != r.lvl[i])) begin
				if ((r.cnt[i] + tic_pkg::FILT_INC) >= thr) begin
					next_r.lvl[i] = r.s3[i];
					next_r.cnt[i] = 20'h0;
				end else begin
					next_r.cnt[i] = r.cnt[i] + tic_pkg::FILT_INC;
				end
			end else begin
				next_r.cnt[i] = 20'h0;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

endmodule

// ==== hdl/tic_trigger_input.sv ====
`timescale 1ns/1ps
module tic_trigger_input (
	input  wire logic        pclk,            // System clock
	input  wire logic        presetn,         // Async reset, active low
	input  wire logic [11:0] paddr,           // APB address
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB direction
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error on unmapped address
	input  wire logic [7:0]  rear_in,         // Rear digital input pins
	input  wire logic [3:0]  front_in,        // Front digital input pins
	input  wire logic        prev_trigger_in, // Pulse from previous camera process
	output logic             trigger_pulse,   // Released pulse to pulse shapers
	output logic             rate_loss_event, // Pulse lost to rate limit
	output logic             shaper_halt,     // Immediate stop to shapers
	output logic             trigger_active   // Run state is active
);

	typedef struct packed {
		tic_pkg::tic_run_t run;
		tic_pkg::tic_src_t mode;
		logic              queue_en;
		logic [3:0]        insel;
		logic [31:0]       rate;
		logic              sim_en;
		logic [31:0]       sim_rate;
		logic [15:0]       filt_time;
		logic              loss;
		logic [7:0]        qcnt;
		logic [32:0]       gap;
		logic [32:0]       gen_cnt;
		logic              sel_prev;
		logic              sw_req;
		logic [7:0]        rear;
		logic [3:0]        front;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              trig;
		logic              loss_evt;
		logic              halt;
		logic              active;
	} tic_state_t;

	localparam tic_state_t STATE_RST = '{
		run:       tic_pkg::RUN_DRAIN,
		mode:      tic_pkg::SRC_GENERATOR,
		rate:      tic_pkg::RATE_RST,
		filt_time: tic_pkg::FILT_TIME_RST,
		gap:       '1,
		default:   '0
	};

	tic_state_t  r;
	tic_state_t  next_r;
	tic_flt_if   flt ();
	logic [31:0] rd_data;
	logic        mapped;
	logic        setup;
	logic        done;
	logic [31:0] eff_units;
	logic [32:0] eff_cyc;
	logic        gap_ok;
	logic        sel_lvl;
	logic        req;
	logic        fresh;
	logic        release_p;
	logic        lost;
	logic        q_full;
	logic        q_empty;

	// One filter setting feeds every input
	assign flt.raw         = {front_in, rear_in};
	assign flt.filter_time = r.filt_time;

	tic_glitch_filter u_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.fl      (flt.filt)
	);

	// Register outputs
	assign prdata          = r.prdata;
	assign pready          = r.pready;
	assign pslverr         = r.pslverr;
	assign trigger_pulse   = r.trig;
	assign rate_loss_event = r.loss_evt;
	assign shaper_halt     = r.halt;
	assign trigger_active  = r.active;

	// Read mux and address decode
	always_comb begin
		rd_data = 32'h0;
		mapped  = 1'b1;
		unique case (paddr)
			tic_pkg::ADDR_RUN:      rd_data = {30'h0, r.run};
			tic_pkg::ADDR_MODE:     rd_data = (32'(r.insel) << tic_pkg::INSEL_LSB)
			                                | (32'(r.queue_en) << tic_pkg::QUEUE_EN_BIT)
			                                | (32'(r.mode) << tic_pkg::MODE_LSB);
			tic_pkg::ADDR_RATE:     rd_data = r.rate;
			tic_pkg::ADDR_SIM_CTRL: rd_data = 32'(r.sim_en) << tic_pkg::SIM_EN_BIT;
			tic_pkg::ADDR_SIM_RATE: rd_data = r.sim_rate;
			tic_pkg::ADDR_FILT:     rd_data = {16'h0, r.filt_time};
			tic_pkg::ADDR_REAR:     rd_data = {24'h0, r.rear};
			tic_pkg::ADDR_FRONT:    rd_data = {28'h0, r.front};
			tic_pkg::ADDR_STATUS:   rd_data = (32'(r.qcnt) << tic_pkg::QCNT_LSB)
			                                | (32'(r.loss) << tic_pkg::LOSS_BIT);
			tic_pkg::ADDR_SW_TRIG:  rd_data = 32'h0;
			default:                mapped  = 1'b0;
		endcase
	end

	// Effective period, limited by simulator rate and fastest legal rate
	always_comb begin
		eff_units = r.rate;
		if (r.sim_en && (r.sim_rate > r.rate)) begin
			eff_units = r.sim_rate;
		end
		if (eff_units < tic_pkg::RATE_MIN) begin
			eff_units = tic_pkg::RATE_MIN;
		end
		eff_cyc = {eff_units, 1'b0};
		gap_ok  = r.gap >= (eff_cyc - 33'h1);
	end

	// Source selection and edge detection on the filtered level
	always_comb begin
		sel_lvl = 1'b0;
		if (32'(r.insel) < tic_pkg::NUM_IN) begin
			sel_lvl = flt.levels[r.insel];
		end
		unique case (r.mode)
			tic_pkg::SRC_GENERATOR: req = 1'b0;
			tic_pkg::SRC_EXTERNAL:  req = sel_lvl & ~r.sel_prev;
			tic_pkg::SRC_SOFTWARE:  req = r.sw_req;
			tic_pkg::SRC_CHAINED:   req = prev_trigger_in;
		endcase
		fresh   = req && (r.run == tic_pkg::RUN_ACTIVE);
		q_empty = r.qcnt == 8'h0;
		q_full  = r.qcnt == tic_pkg::QUEUE_MAX;
	end

	// Next-state logic: bus slave, rate limiter, queue, generator
	always_comb begin
		next_r          = r;
		next_r.trig     = 1'b0;
		next_r.loss_evt = 1'b0;
		next_r.sw_req   = 1'b0;
		next_r.sel_prev = sel_lvl;
		next_r.rear     = flt.levels[7:0];
		next_r.front    = flt.levels[11:8];
		release_p       = 1'b0;
		lost            = 1'b0;
		setup           = psel && !penable;
		done            = psel && penable && r.pready;
		next_r.gap      = (r.gap == '1) ? r.gap : r.gap + 33'h1;

		// Trigger engine
		if (r.run == tic_pkg::RUN_IMMEDIATE) begin
			next_r.gap = r.gap;
		end else if (r.mode == tic_pkg::SRC_GENERATOR) begin
			if (r.run == tic_pkg::RUN_ACTIVE) begin
				if (r.gen_cnt >= (eff_cyc - 33'h1)) begin
					release_p      = 1'b1;
					next_r.gen_cnt = 33'h0;
				end else begin
					next_r.gen_cnt = r.gen_cnt + 33'h1;
				end
			end
			if (!q_empty && gap_ok) begin
				release_p   = 1'b1;
				next_r.qcnt = r.qcnt - 8'h1;
			end
		end else if (r.queue_en) begin
			release_p = gap_ok && (fresh || !q_empty);
			if (fresh && q_full) begin
				lost = 1'b1;
			end
			if (fresh && !q_full && !(q_empty && gap_ok)) begin
				next_r.qcnt = r.qcnt + 8'h1;
			end
			if (release_p && !q_empty) begin
				next_r.qcnt = next_r.qcnt - 8'h1;
			end
		end else begin
			release_p = fresh && gap_ok;
			lost      = fresh && !gap_ok;
			if (!q_empty && gap_ok && !fresh) begin
				release_p   = 1'b1;
				next_r.qcnt = r.qcnt - 8'h1;
			end
		end
		if (release_p) begin
			next_r.trig = 1'b1;
			next_r.gap  = 33'h0;
		end
		if (lost) begin
			next_r.loss_evt = 1'b1;
		end

		// APB setup phase: answer prepared, ready next cycle
		next_r.pready = 1'b0;
		if (setup) begin
			next_r.pready  = 1'b1;
			next_r.pslverr = !mapped;
			next_r.prdata  = rd_data;
		end
		if (done) begin
			next_r.pslverr = 1'b0;
		end

		// APB writes take effect at the completing edge
		if (done && pwrite && mapped) begin
			unique case (paddr)
				tic_pkg::ADDR_RUN: begin
					if (pwdata[1:0] != 2'h3) begin
						next_r.run = tic_pkg::tic_run_t'(pwdata[1:0]);
						if ((pwdata[1:0] == tic_pkg::RUN_ACTIVE) && (r.run != tic_pkg::RUN_ACTIVE)) begin
							next_r.qcnt    = 8'h0;
							next_r.gen_cnt = 33'h0;
							next_r.gap     = '1;
						end
					end
				end
				tic_pkg::ADDR_MODE: begin
					next_r.mode     = tic_pkg::tic_src_t'(pwdata[tic_pkg::MODE_LSB +: 2]);
					next_r.queue_en = pwdata[tic_pkg::QUEUE_EN_BIT];
					next_r.insel    = pwdata[tic_pkg::INSEL_LSB +: 4];
				end
				tic_pkg::ADDR_RATE:     next_r.rate      = pwdata;
				tic_pkg::ADDR_SIM_CTRL: next_r.sim_en    = pwdata[tic_pkg::SIM_EN_BIT];
				tic_pkg::ADDR_SIM_RATE: next_r.sim_rate  = pwdata;
				tic_pkg::ADDR_FILT:     next_r.filt_time = pwdata[15:0];
				tic_pkg::ADDR_SW_TRIG:  next_r.sw_req    = pwdata[tic_pkg::SW_PULSE_BIT];
				default:                next_r.rear      = flt.levels[7:0];
			endcase
		end

		// Sticky loss flag, a new loss beats the clear
		if (done && pwrite && (paddr == tic_pkg::ADDR_STATUS) && pwdata[tic_pkg::LOSS_BIT]) begin
			next_r.loss = 1'b0;
		end
		if (lost) begin
			next_r.loss = 1'b1;
		end

		// Status outputs follow the run state
		next_r.halt   = next_r.run == tic_pkg::RUN_IMMEDIATE;
		next_r.active = next_r.run == tic_pkg::RUN_ACTIVE;

		// A halt taking effect now swallows this cycle's pulse
		if (next_r.halt) begin
			next_r.trig     = 1'b0;
			next_r.loss_evt = 1'b0;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= STATE_RST;
		end else begin
			r <= next_r;
		end
	end

endmodule

// ==== include/tic_flt_if.sv ====
`timescale 1ns/1ps
interface tic_flt_if;
	logic [11:0] raw;
	logic [15:0] filter_time;
	logic [11:0] levels;
	modport filt (input raw, input filter_time, output levels);
	modport user (output raw, output filter_time, input levels);
endinterface

// ==== include/tic_pkg.sv ====
package tic_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned CLK_PERIOD_PS   = 10_000;

	// Glitch filter time base: setting counts steps of 3.2 ns
	localparam int unsigned FILT_STEP_PS    = 3_200;
	localparam int unsigned FILT_FRAC       = 8;
	localparam int unsigned FILT_DEFAULT_PS = 1_000_000;
	localparam logic [19:0] FILT_INC        = 20'(CLK_PERIOD_PS * FILT_FRAC / FILT_STEP_PS);
	localparam logic [15:0] FILT_TIME_RST   = 16'((FILT_DEFAULT_PS + FILT_STEP_PS - 1) / FILT_STEP_PS);

	// Rate setting is a period in units of two clock cycles
	localparam int unsigned RATE_UNIT_CYCLES = 2;
	localparam int unsigned RATE_UNIT_PS     = CLK_PERIOD_PS * RATE_UNIT_CYCLES;
	localparam int unsigned RATE_DEFAULT_HZ  = 8;
	localparam int unsigned RATE_MIN_PER_PS  = 32_000;
	localparam logic [31:0] RATE_RST         = 32'(CLK_HZ / (RATE_DEFAULT_HZ * RATE_UNIT_CYCLES));
	localparam logic [31:0] RATE_MIN         = 32'((RATE_MIN_PER_PS + RATE_UNIT_PS - 1) / RATE_UNIT_PS);

	// Inputs and queue
	localparam int unsigned NUM_REAR  = 8;
	localparam int unsigned NUM_FRONT = 4;
	localparam int unsigned NUM_IN    = NUM_REAR + NUM_FRONT;
	localparam logic [7:0]  QUEUE_MAX = 8'hff;

	// Register byte offsets
	localparam logic [11:0] ADDR_RUN      = 12'h000;
	localparam logic [11:0] ADDR_MODE     = 12'h004;
	localparam logic [11:0] ADDR_RATE     = 12'h008;
	localparam logic [11:0] ADDR_SIM_CTRL = 12'h00c;
	localparam logic [11:0] ADDR_SIM_RATE = 12'h010;
	localparam logic [11:0] ADDR_FILT     = 12'h014;
	localparam logic [11:0] ADDR_REAR     = 12'h018;
	localparam logic [11:0] ADDR_FRONT    = 12'h01c;
	localparam logic [11:0] ADDR_STATUS   = 12'h020;
	localparam logic [11:0] ADDR_SW_TRIG  = 12'h024;

	// Field positions
	localparam int unsigned MODE_LSB      = 0;
	localparam int unsigned QUEUE_EN_BIT  = 4;
	localparam int unsigned INSEL_LSB     = 8;
	localparam int unsigned LOSS_BIT      = 0;
	localparam int unsigned QCNT_LSB      = 8;
	localparam int unsigned SIM_EN_BIT    = 0;
	localparam int unsigned SW_PULSE_BIT  = 0;

	// Run state encodings
	typedef enum logic [1:0] {
		RUN_ACTIVE    = 2'h0,
		RUN_IMMEDIATE = 2'h1,
		RUN_DRAIN     = 2'h2
	} tic_run_t;

	// Source mode encodings
	typedef enum logic [1:0] {
		SRC_GENERATOR = 2'h0,
		SRC_EXTERNAL  = 2'h1,
		SRC_SOFTWARE  = 2'h2,
		SRC_CHAINED   = 2'h3
	} tic_src_t;

endpackage

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, prev_trigger_in = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, v, seed = 32'h41bd;
	logic        pready, pslverr, trigger_pulse, rate_loss_event, shaper_halt, trigger_active;
	logic [7:0]  rear_in;
	logic [3:0]  front_in;
	logic [32:0] exp_q[$];
	int          n_fail = 0, n_tests = 0, n_pulse = 0, n_loss = 0, cyc = 0, last = -1, gap = 0, p, l;

	always #5 pclk = ~pclk;
	tic_trigger_input uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rear_in(rear_in), .front_in(front_in), .prev_trigger_in(prev_trigger_in),
		.trigger_pulse(trigger_pulse), .rate_loss_event(rate_loss_event), .shaper_halt(shaper_halt),
		.trigger_active(trigger_active));
	tic_src_model src (.pclk(pclk), .rear_in(rear_in), .front_in(front_in));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		cmp(33'(got), 33'(exp));
	endtask
	// Bus transfer; a read notes its expected error and data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		if (!w) exp_q.push_back(e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		apb(0, a, 0, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic snap(input int g);
		#1;
		gap = g;
		last = -1;
		p = n_pulse;
		l = n_loss;
	endtask
	task automatic chk(input int ep, input int el);
		cmp_cnt(n_pulse - p, ep);
		cmp_cnt(n_loss - l, el);
	endtask
	task automatic print_verdict();
		$display("failures %0d of %0d checks", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watcher: read results against notes, pulse spacing
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready && !pwrite)
			cmp({pslverr, prdata}, exp_q.pop_front());
		if (rate_loss_event)
			n_loss++;
		if (trigger_pulse) begin
			if (gap > 0 && last >= 0)
				cmp_cnt(cyc - last, gap);
			last = cyc;
			n_pulse++;
		end
	end
	// Hang guard
	always @(posedge pclk)
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rd(tic_pkg::ADDR_RUN, 33'h2);
		rd(tic_pkg::ADDR_FILT, 33'(tic_pkg::FILT_TIME_RST));
		rd(tic_pkg::ADDR_RATE, 33'(tic_pkg::RATE_RST));
		rd(12'h030, 33'h100000000);
		for (int i = 0; i < 4; i++) begin
			wr(tic_pkg::ADDR_RUN, 32'(i));
			rd(tic_pkg::ADDR_RUN, 33'((i < 3) ? i : 2));
		end
		// Generator, software write ignored, then drain
		wr(tic_pkg::ADDR_RATE, 32'h3);
		wr(tic_pkg::ADDR_RUN, 32'h0);
		snap(6);
		wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		snap(6);
		wait_n(30);
		chk(5, 0);
		wr(tic_pkg::ADDR_RUN, 32'h2);
		wait_n(3);
		snap(0);
		wait_n(30);
		chk(0, 0);
		// Software trigger too fast, no queue
		wr(tic_pkg::ADDR_MODE, 32'h2);
		wr(tic_pkg::ADDR_RATE, 32'h5);
		wr(tic_pkg::ADDR_RUN, 32'h0);
		snap(0);
		wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wait_n(20);
		chk(1, 1);
		rd(tic_pkg::ADDR_STATUS, 33'h1);
		wr(tic_pkg::ADDR_STATUS, 32'h1);
		rd(tic_pkg::ADDR_STATUS, 33'h0);
		// Queue on: none lost, first fires at once, rest queued, then drained in drain stop
		wr(tic_pkg::ADDR_MODE, 32'h12);
		snap(10);
		repeat (3) wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wait_n(30);
		chk(3, 0);
		snap(10);
		repeat (3) wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wr(tic_pkg::ADDR_RUN, 32'h2);
		wait_n(30);
		chk(3, 0);
		// Immediate stop freezes queue, restart clears it
		wr(tic_pkg::ADDR_RATE, 32'h32);
		wr(tic_pkg::ADDR_RUN, 32'h0);
		snap(0);
		repeat (3) wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wr(tic_pkg::ADDR_RUN, 32'h1);
		wait_n(150);
		rd(tic_pkg::ADDR_STATUS, 33'h200);
		wr(tic_pkg::ADDR_RUN, 32'h0);
		rd(tic_pkg::ADDR_STATUS, 33'h0);
		wait_n(150);
		chk(1, 0);
		// Chained source
		wr(tic_pkg::ADDR_RATE, 32'h2);
		wr(tic_pkg::ADDR_MODE, 32'h3);
		snap(0);
		@(posedge pclk) prev_trigger_in <= 1;
		@(posedge pclk) prev_trigger_in <= 0;
		wait_n(5);
		chk(1, 0);
		// Simulator cap: slower simulator period sets the spacing
		wr(tic_pkg::ADDR_SIM_RATE, 32'h5);
		wr(tic_pkg::ADDR_SIM_CTRL, 32'h1);
		wr(tic_pkg::ADDR_MODE, 32'h12);
		snap(10);
		repeat (2) wr(tic_pkg::ADDR_SW_TRIG, 32'h1);
		wait_n(20);
		chk(2, 0);
		wr(tic_pkg::ADDR_SIM_CTRL, 32'h0);
		// External pin: spike rejected, delay, monitors
		wr(tic_pkg::ADDR_FILT, 32'h19);
		wr(tic_pkg::ADDR_MODE, 32'h501);
		snap(0);
		src.spike(12'h020, 3);
		wait_n(20);
		rd(tic_pkg::ADDR_REAR, 33'h0);
		src.set(12'h020);
		wait_n(4);
		rd(tic_pkg::ADDR_REAR, 33'h0);
		wait_n(10);
		rd(tic_pkg::ADDR_REAR, 33'h20);
		chk(1, 0);
		for (int i = 0; i < 4; i++) begin
			v = xs();
			src.set(v[11:0]);
			wait_n(30);
			rd(tic_pkg::ADDR_REAR, 33'(v[7:0]));
			rd(tic_pkg::ADDR_FRONT, 33'(v[11:8]));
		end
		// Second reset
		presetn <= 0;
		wait_n(2);
		@(posedge pclk) presetn <= 1;
		rd(tic_pkg::ADDR_RUN, 33'h2);
		print_verdict();
	end
endmodule

// ==== tb/tic_checker.sv ====
`timescale 1ns/1ps
module tic_checker (
	input wire logic        pclk,            // Clock
	input wire logic        presetn,         // Reset
	input wire logic [11:0] paddr,           // Address
	input wire logic        psel,            // Select
	input wire logic        penable,         // Enable
	input wire logic        pwrite,          // Direction
	input wire logic [31:0] pwdata,          // Write data
	input wire logic        pready,          // Ready
	input wire logic        pslverr,         // Error
	input wire logic        trigger_pulse,   // Pulse out
	input wire logic        rate_loss_event, // Loss
	input wire logic        shaper_halt,     // Halt
	input wire logic        trigger_active   // Active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed write to the run state
	logic run_wr;
	assign run_wr = psel && penable && pready && pwrite && paddr == tic_pkg::ADDR_RUN;

	ready_setup_a: assert property (psel && !penable |=> pready) else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready long");
	err_ready_a: assert property (pslverr |-> pready) else $error("error alone");
	state_excl_a: assert property (!(shaper_halt && trigger_active)) else $error("two states");
	go_active_a: assert property (run_wr && pwdata[1:0] == 2'h0 |-> ##[1:2] trigger_active)
		else $error("not active");
	go_halt_a: assert property (run_wr && pwdata[1:0] == 2'h1 |-> ##[1:2] shaper_halt)
		else $error("not halted");
	go_drain_a: assert property (run_wr && pwdata[1:0] == 2'h2 |-> ##2 !trigger_active && !shaper_halt)
		else $error("not drained");
	halt_quiet_a: assert property (shaper_halt |-> !trigger_pulse && !rate_loss_event)
		else $error("pulse in halt");
	pulse_gap_a: assert property (trigger_pulse |=> !trigger_pulse [*3]) else $error("pulses close");

	cover property (trigger_pulse);
	cover property (rate_loss_event);
	cover property (shaper_halt && pready);
endmodule

bind tic_trigger_input tic_checker chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.trigger_pulse(trigger_pulse), .rate_loss_event(rate_loss_event), .shaper_halt(shaper_halt),
	.trigger_active(trigger_active));

// ==== tb/tic_src_model.sv ====
`timescale 1ns/1ps
module tic_src_model (
	input wire logic  pclk,    // Clock
	output logic [7:0] rear_in, // Rear pins
	output logic [3:0] front_in // Front pins
);
	initial {front_in, rear_in} = 12'h000;
	// New pin levels just after an edge
	task automatic set(input logic [11:0] v);
		@(posedge pclk);
		{front_in, rear_in} <= v;
	endtask
	// Spike shorter than the filter time, then back
	task automatic spike(input logic [11:0] v, input int n);
		logic [11:0] o;
		o = {front_in, rear_in};
		set(v);
		repeat (n) @(posedge pclk);
		{front_in, rear_in} <= o;
	endtask
endmodule
